// file: mba_pkg.sv
// Constants, encodings and shared helpers for the Modbus RTU slave access block
// What this block does
// - Link starts at 9600 baud, eight data bits, no parity, two stop bits.
// - Slave answers at address 10 until another address is configured.
// - Framing field: 0 two stops, 1 even parity one stop, 2 odd parity.
// - Unsigned values: 16-bit take one register, 32-bit take two.
// - One-register mask: bit 1 temperature, next bits parameters 1 to 4.
// - A 32-bit mask spans two consecutive registers with the same meaning.
// - Real values are single-precision floats filling two registers each.
// - Text packs two 8-bit characters into each 16-bit register.
// - Dates take eight registers: minute, hour, day, month, four-digit year.
// - Multi-register values keep the most significant word at the lowest address.
// - Function 0x03 reads a block of consecutive registers.
// - Function 0x06 writes one register.
// - Function 0x10 writes a run of consecutive registers in one request.
// - Function 0x11 answers with the sensor identification.
package mba_pkg;
  ////////////////////////////////////////////////////////////////////////////////
  // Timing
  localparam int CLK_HZ = 25_000_000;
  localparam int BAUD = 9600;
  localparam int BIT_CYC = CLK_HZ / BAUD;
  // Silence of 3.5 characters of 11 bits, least time rounded up
  localparam int T35_US = 4011;
  localparam int T35_CYC_DEF = T35_US * (CLK_HZ / 1_000_000);
  ////////////////////////////////////////////////////////////////////////////////
  // Character framing
  localparam logic [1:0] CFG_TWO_STOP = 2'h0;
  localparam logic [1:0] CFG_EVEN = 2'h1;
  localparam logic [1:0] CFG_ODD = 2'h2;
  localparam logic [3:0] LAST_NOPAR = 4'h9;
  localparam logic [3:0] LAST_PAR = 4'ha;
  localparam logic [3:0] TX_LAST = 4'ha;
  ////////////////////////////////////////////////////////////////////////////////
  // Protocol
  localparam logic [7:0] DEF_ADDR = 8'h0a;
  localparam logic [7:0] ADDR_MIN = 8'h01;
  localparam logic [7:0] ADDR_MAX = 8'hf7;
  localparam logic [7:0] FC_RD = 8'h03;
  localparam logic [7:0] FC_WR1 = 8'h06;
  localparam logic [7:0] FC_WRN = 8'h10;
  localparam logic [7:0] FC_ID = 8'h11;
  localparam logic [7:0] EXC_FLAG = 8'h80;
  localparam logic [7:0] EXC_NONE = 8'h00;
  localparam logic [7:0] EXC_FUNC = 8'h01;
  localparam logic [7:0] EXC_ADDR = 8'h02;
  localparam logic [7:0] EXC_VAL = 8'h03;
  localparam logic [7:0] ID_COUNT = 8'h02;
  localparam logic [7:0] RUN_ON = 8'hff;
  localparam logic [15:0] RD_MAX = 16'h007d;
  localparam logic [15:0] WR_MAX = 16'h007b;
  localparam logic [15:0] CRC_INIT = 16'hffff;
  localparam logic [15:0] CRC_POLY = 16'ha001;
  // Request byte positions and lengths
  localparam logic [8:0] IX_DST = 9'h000;
  localparam logic [8:0] IX_FC = 9'h001;
  localparam logic [8:0] IX_AH = 9'h002;
  localparam logic [8:0] IX_AL = 9'h003;
  localparam logic [8:0] IX_QH = 9'h004;
  localparam logic [8:0] IX_QL = 9'h005;
  localparam logic [8:0] IX_BC = 9'h006;
  localparam logic [8:0] IX_DATA = 9'h007;
  localparam logic [8:0] LEN_MIN = 9'h004;
  localparam logic [8:0] LEN_WR1 = 9'h008;
  localparam logic [8:0] LEN_WRN_BASE = 9'h009;
  localparam logic [8:0] BUF_FULL = 9'h100;
  // Reply lengths before the check sequence
  localparam logic [7:0] TXL_EXC = 8'h03;
  localparam logic [7:0] TXL_ECHO = 8'h06;
  localparam logic [7:0] TXL_ID = 8'h05;
  localparam logic [7:0] TXL_RD_BASE = 8'h03;
  ////////////////////////////////////////////////////////////////////////////////
  // Register space
  localparam int REG_AW = 10;
  localparam int BUF_AW = 8;
  localparam logic [16:0] REG_DEPTH = 17'h00400;
  localparam logic [15:0] REG_MEAS = 16'h0001;
  localparam logic [15:0] REG_SLAVE = 16'h00a3;
  localparam logic [15:0] REG_FRAME = 16'h00bc;
  localparam logic [15:0] REG_COEF_HI = 16'h014c;
  localparam logic [15:0] REG_COEF_LO = 16'h014d;
  ////////////////////////////////////////////////////////////////////////////////
  // Helpers
  function automatic logic [15:0] crc16_byte(input logic [15:0] c, input logic [7:0] d);
    logic [15:0] r;
    r = c ^ {8'h00, d};
    for (int i = 0; i < 8; i++) begin
      r = r[0] ? ((r >> 1) ^ CRC_POLY) : (r >> 1);
    end
    return r;
  endfunction : crc16_byte

  function automatic logic parity_bit(input logic [7:0] d, input logic [1:0] cfg);
    return (cfg == CFG_ODD) ? ~^d : ^d;
  endfunction : parity_bit
endpackage : mba_pkg

// file: mba_mem.sv
// Simple dual-port memory with registered read data
`timescale 1ns/10ps
module mba_mem #(
  parameter int W = 16,
  parameter int AW = 10
) (
  input wire logic i_clk_sys,
  input wire logic i_we,
  input wire logic [AW-1:0] i_waddr,
  input wire logic [W-1:0] i_wdata,
  input wire logic [AW-1:0] i_raddr,
  output logic [W-1:0] o_rdata
);
  logic [W-1:0] mem_r [2**AW];

  // No reset on the array, so it maps onto block memory
  always_ff @(posedge i_clk_sys) begin
    if (i_we) begin
      mem_r[i_waddr] <= i_wdata;
    end
    o_rdata <= mem_r[i_raddr];
  end
endmodule : mba_mem

// file: mba_uart.sv
// Half-duplex serial character engine with selectable parity and stop bits
`timescale 1ns/10ps
module mba_uart
  import mba_pkg::*;
#(
  parameter int BIT_CYC_P = BIT_CYC
) (
  input wire logic i_clk_sys,
  input wire logic i_rst_n,
  input wire logic i_rx,
  input wire logic [1:0] i_cfg,
  input wire logic i_tx_go,
  input wire logic [7:0] i_tx_byte,
  output logic o_tx,
  output logic o_tx_done,
  output logic o_rx_valid,
  output logic [7:0] o_rx_data,
  output logic o_rx_err,
  output logic o_rx_busy
);
  logic s1_r, s2_r;
  logic rb_r, rb_nxt, rv_nxt, re_nxt;
  logic [11:0] rc_r, rc_nxt, tc_r, tc_nxt;
  logic [3:0] rn_r, rn_nxt, tn_r, tn_nxt, last;
  logic [9:0] rs_r, rs_nxt, sh;
  logic [7:0] rd_nxt;
  logic tb_r, tb_nxt, tx_nxt, td_nxt;
  logic [10:0] ts_r, ts_nxt;
  // Bit and half-bit reload values
  localparam logic [11:0] BIT_N = 12'(BIT_CYC_P - 1);
  localparam logic [11:0] HALF_N = 12'(BIT_CYC_P / 2 - 1);

  assign o_rx_busy = rb_r;

  // Receiver: mid-bit sampling, stops after the first stop bit
  always_comb begin
    last = (i_cfg == CFG_TWO_STOP) ? LAST_NOPAR : LAST_PAR;
    sh = {s2_r, rs_r[9:1]};
    rb_nxt = rb_r;
    rc_nxt = rc_r;
    rn_nxt = rn_r;
    rs_nxt = rs_r;
    rv_nxt = 1'b0;
    re_nxt = o_rx_err;
    rd_nxt = o_rx_data;
    if (!rb_r) begin
      if (!s2_r) begin
        rb_nxt = 1'b1;
        rc_nxt = HALF_N;
        rn_nxt = 4'h0;
      end
    end else if (rc_r != 12'h000) begin
      rc_nxt = rc_r - 12'h001;
    end else begin
      rc_nxt = BIT_N;
      rn_nxt = rn_r + 4'h1;
      rs_nxt = sh;
      if (rn_r == 4'h0 && s2_r) begin
        rb_nxt = 1'b0; // Glitch, not a start bit
      end else if (rn_r == last) begin
        rb_nxt = 1'b0;
        rv_nxt = 1'b1;
        if (last == LAST_NOPAR) begin
          rd_nxt = sh[8:1];
          re_nxt = !s2_r;
        end else begin
          rd_nxt = sh[7:0];
          re_nxt = !s2_r | (sh[8] != parity_bit(sh[7:0], i_cfg));
        end
      end
    end
  end

  // Transmitter: always 11 bit times, second stop or parity in slot 9
  always_comb begin
    tb_nxt = tb_r;
    tc_nxt = tc_r;
    tn_nxt = tn_r;
    ts_nxt = ts_r;
    td_nxt = 1'b0;
    if (!tb_r) begin
      if (i_tx_go) begin
        tb_nxt = 1'b1;
        tc_nxt = BIT_N;
        tn_nxt = 4'h0;
        ts_nxt = {1'b1, (i_cfg == CFG_TWO_STOP) ? 1'b1 : parity_bit(i_tx_byte, i_cfg),
                  i_tx_byte, 1'b0};
      end
    end else if (tc_r != 12'h000) begin
      tc_nxt = tc_r - 12'h001;
    end else begin
      tc_nxt = BIT_N;
      ts_nxt = {1'b1, ts_r[10:1]};
      tn_nxt = tn_r + 4'h1;
      if (tn_r == TX_LAST) begin
        tb_nxt = 1'b0;
        td_nxt = 1'b1;
      end
    end
    tx_nxt = tb_nxt ? ts_nxt[0] : 1'b1;
  end

  always_ff @(posedge i_clk_sys or negedge i_rst_n) begin
    if (!i_rst_n) begin
      s1_r <= 1'b1;
      s2_r <= 1'b1;
      rb_r <= 1'b0;
      rc_r <= 12'h000;
      rn_r <= 4'h0;
      rs_r <= 10'h3ff;
      o_rx_valid <= 1'b0;
      o_rx_data <= 8'h00;
      o_rx_err <= 1'b0;
      tb_r <= 1'b0;
      tc_r <= 12'h000;
      tn_r <= 4'h0;
      ts_r <= 11'h7ff;
      o_tx <= 1'b1;
      o_tx_done <= 1'b0;
    end else begin
      s1_r <= i_rx;
      s2_r <= s1_r;
      rb_r <= rb_nxt;
      rc_r <= rc_nxt;
      rn_r <= rn_nxt;
      rs_r <= rs_nxt;
      o_rx_valid <= rv_nxt;
      o_rx_data <= rd_nxt;
      o_rx_err <= re_nxt;
      tb_r <= tb_nxt;
      tc_r <= tc_nxt;
      tn_r <= tn_nxt;
      ts_r <= ts_nxt;
      o_tx <= tx_nxt;
      o_tx_done <= td_nxt;
    end
  end
endmodule : mba_uart

// file: mba_slave.sv
// Modbus RTU slave access: framing, decode, register file and reply
`timescale 1ns/10ps
module mba_slave
  import mba_pkg::*;
#(
  parameter int unsigned T35_CYC = T35_CYC_DEF,
  parameter int BIT_CYC_P = BIT_CYC,
  parameter logic [7:0] SLAVE_ID = 8'h5a // Arbitrary identification value
) (
  input wire logic i_clk_sys,
  input wire logic i_rst_n,
  input wire logic i_rx,
  input wire logic i_upd_valid,
  input wire logic [REG_AW-1:0] i_upd_addr,
  input wire logic [15:0] i_upd_data,
  output logic o_upd_ready,
  output logic o_tx,
  output logic o_tx_en,
  output logic [7:0] o_slave_addr,
  output logic [1:0] o_frame_cfg,
  output logic o_wr_strobe,
  output logic [REG_AW-1:0] o_wr_addr,
  output logic [15:0] o_wr_data,
  output logic o_meas_req,
  output logic [15:0] o_meas_mask,
  output logic [31:0] o_coef_mask
);
  typedef enum logic [3:0] {
    S_RX, S_CHECK, S_WR1, S_WR_HI, S_WR_LO, S_WR_DO, S_TX_PREP, S_TX_LOAD, S_TX_WAIT, S_APPLY
  } mba_state_t;

  localparam logic [16:0] SIL_END = 17'(T35_CYC - 1);

  mba_state_t state_r, state_nxt;
  logic rx_valid, rx_err, rx_busy, tx_done;
  logic [7:0] rx_data, buf_q, tx_sel;
  logic [8:0] cnt_r, cnt_nxt;
  logic bad_r, bad_nxt, frame_clr, frame_end, span_bad, buf_we;
  logic [16:0] sil_r, sil_nxt;
  logic [15:0] crc_r, crc_nxt, txcrc_r, txcrc_nxt, a_r, a_nxt, q_r, q_nxt, mem_q;
  logic [7:0] dst_r, dst_nxt, fc_r, fc_nxt, bc_r, bc_nxt, hi_r, hi_nxt, exc_r, exc_nxt;
  logic [7:0] tx_len_r, tx_len_nxt, idx_r, idx_nxt, rd_word, tx_byte_r, tx_byte_nxt;
  logic [7:0] buf_raddr, pend_slave_r, pend_slave_nxt, slave_nxt;
  logic [6:0] w_r, w_nxt;
  logic tx_go_r, tx_go_nxt, tx_en_nxt, upd_ready_nxt, mwe, mem_we, meas_req_nxt;
  logic [REG_AW-1:0] mwaddr, mem_waddr, mem_raddr, wr_addr_nxt;
  logic [15:0] mwdata, mem_wdata, wr_data_nxt, meas_mask_nxt;
  logic [1:0] pend_cfg_r, pend_cfg_nxt, cfg_nxt;
  logic [31:0] coef_nxt;

  ////////////////////////////////////////////////////////////////////////////////
  mba_uart #(.BIT_CYC_P(BIT_CYC_P)) u_uart (
    .i_clk_sys(i_clk_sys),
    .i_rst_n(i_rst_n),
    .i_rx(i_rx),
    .i_cfg(o_frame_cfg),
    .i_tx_go(tx_go_r),
    .i_tx_byte(tx_byte_r),
    .o_tx(o_tx),
    .o_tx_done(tx_done),
    .o_rx_valid(rx_valid),
    .o_rx_data(rx_data),
    .o_rx_err(rx_err),
    .o_rx_busy(rx_busy)
  );

  // Request bytes are held until the check sequence has been proven
  mba_mem #(.W(8), .AW(BUF_AW)) u_buf (
    .i_clk_sys(i_clk_sys),
    .i_we(buf_we),
    .i_waddr(cnt_r[BUF_AW-1:0]),
    .i_wdata(rx_data),
    .i_raddr(buf_raddr),
    .o_rdata(buf_q)
  );

  mba_mem #(.W(16), .AW(REG_AW)) u_regs (
    .i_clk_sys(i_clk_sys),
    .i_we(mem_we),
    .i_waddr(mem_waddr),
    .i_wdata(mem_wdata),
    .i_raddr(mem_raddr),
    .o_rdata(mem_q)
  );

  // Master writes win; sensor updates only when the port was offered
  assign mem_we = mwe | (i_upd_valid & o_upd_ready);
  assign mem_waddr = mwe ? mwaddr : i_upd_addr;
  assign mem_wdata = mwe ? mwdata : i_upd_data;
  assign frame_end = (sil_r == SIL_END) && (cnt_r != 9'h000 || bad_r);
  assign span_bad = ({1'b0, a_r} + {1'b0, q_r}) > REG_DEPTH;
  assign rd_word = idx_r - TXL_RD_BASE;
  assign mem_raddr = a_r[REG_AW-1:0] + {3'h0, rd_word[7:1]};

  ////////////////////////////////////////////////////////////////////////////////
  // Receive: silence timer, byte capture, running check sequence
  always_comb begin
    cnt_nxt = cnt_r;
    bad_nxt = bad_r;
    crc_nxt = crc_r;
    dst_nxt = dst_r;
    fc_nxt = fc_r;
    a_nxt = a_r;
    q_nxt = q_r;
    bc_nxt = bc_r;
    buf_we = 1'b0;
    sil_nxt = sil_r;
    if (rx_busy || rx_valid) begin
      sil_nxt = 17'h00000;
    end else if (sil_r != SIL_END) begin
      sil_nxt = sil_r + 17'h00001;
    end
    if (state_r == S_RX && rx_valid) begin
      buf_we = (cnt_r != BUF_FULL);
      if (cnt_r == BUF_FULL || rx_err) begin
        bad_nxt = 1'b1; // Overlong or mis-framed: the frame is spoilt
      end else begin
        cnt_nxt = cnt_r + 9'h001;
      end
      crc_nxt = crc16_byte(crc_r, rx_data);
      case (cnt_r)
        IX_DST: dst_nxt = rx_data;
        IX_FC: fc_nxt = rx_data;
        IX_AH: a_nxt[15:8] = rx_data;
        IX_AL: a_nxt[7:0] = rx_data;
        IX_QH: q_nxt[15:8] = rx_data;
        IX_QL: q_nxt[7:0] = rx_data;
        IX_BC: bc_nxt = rx_data;
        default: ;
      endcase
    end
    if (frame_clr) begin
      cnt_nxt = 9'h000;
      bad_nxt = 1'b0;
      crc_nxt = CRC_INIT;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Reply byte: header, payload, then check sequence low byte first
  always_comb begin
    tx_sel = 8'h00;
    if (idx_r == tx_len_r) begin
      tx_sel = txcrc_r[7:0];
    end else if (idx_r == tx_len_r + 8'h01) begin
      tx_sel = txcrc_r[15:8];
    end else if (idx_r == IX_DST[7:0]) begin
      tx_sel = o_slave_addr;
    end else if (idx_r == IX_FC[7:0]) begin
      tx_sel = (exc_r != EXC_NONE) ? (fc_r | EXC_FLAG) : fc_r;
    end else if (exc_r != EXC_NONE) begin
      tx_sel = exc_r;
    end else begin
      case (fc_r)
        FC_RD: begin
          if (idx_r == IX_AH[7:0]) begin
            tx_sel = {q_r[6:0], 1'b0};
          end else begin
            tx_sel = rd_word[0] ? mem_q[7:0] : mem_q[15:8];
          end
        end
        FC_ID: begin
          if (idx_r == IX_AH[7:0]) tx_sel = ID_COUNT;
          else if (idx_r == IX_AL[7:0]) tx_sel = SLAVE_ID;
          else tx_sel = RUN_ON;
        end
        default: begin
          if (idx_r == IX_AH[7:0]) tx_sel = a_r[15:8];
          else if (idx_r == IX_AL[7:0]) tx_sel = a_r[7:0];
          else if (idx_r == IX_QH[7:0]) tx_sel = q_r[15:8];
          else tx_sel = q_r[7:0];
        end
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Sequencer: check, decode, write, reply
  always_comb begin
    state_nxt = state_r;
    frame_clr = 1'b0;
    exc_nxt = exc_r;
    tx_len_nxt = tx_len_r;
    idx_nxt = idx_r;
    txcrc_nxt = txcrc_r;
    w_nxt = w_r;
    hi_nxt = hi_r;
    tx_byte_nxt = tx_byte_r;
    tx_go_nxt = 1'b0;
    mwe = 1'b0;
    mwaddr = a_r[REG_AW-1:0];
    mwdata = q_r;
    buf_raddr = IX_DATA[7:0] + {w_r, 1'b0};
    case (state_r)
      S_RX: if (frame_end) state_nxt = S_CHECK;
      S_CHECK: begin
        idx_nxt = 8'h00;
        txcrc_nxt = CRC_INIT;
        exc_nxt = EXC_NONE;
        w_nxt = 7'h00;
        if (bad_r || cnt_r < LEN_MIN || crc_r != 16'h0000 || dst_r != o_slave_addr) begin
          frame_clr = 1'b1; // Silently dropped
          state_nxt = S_RX;
        end else begin
          state_nxt = S_TX_PREP;
          tx_len_nxt = TXL_ECHO;
          case (fc_r)
            FC_RD: begin
              tx_len_nxt = TXL_RD_BASE + {q_r[6:0], 1'b0};
              if (q_r == 16'h0000 || q_r > RD_MAX) exc_nxt = EXC_VAL;
              else if (span_bad) exc_nxt = EXC_ADDR;
            end
            FC_WR1: begin
              if (cnt_r != LEN_WR1) exc_nxt = EXC_VAL;
              else if ({1'b0, a_r} >= REG_DEPTH) exc_nxt = EXC_ADDR;
              else state_nxt = S_WR1;
            end
            FC_WRN: begin
              if (q_r == 16'h0000 || q_r > WR_MAX || {8'h00, bc_r} != {q_r[14:0], 1'b0}
                  || cnt_r != LEN_WRN_BASE + {1'b0, bc_r}) exc_nxt = EXC_VAL;
              else if (span_bad) exc_nxt = EXC_ADDR;
              else state_nxt = S_WR_HI;
            end
            FC_ID: tx_len_nxt = TXL_ID;
            default: exc_nxt = EXC_FUNC;
          endcase
          if (exc_nxt != EXC_NONE) begin
            tx_len_nxt = TXL_EXC;
            state_nxt = S_TX_PREP;
          end
        end
      end
      S_WR1: begin
        mwe = 1'b1;
        state_nxt = S_TX_PREP;
      end
      S_WR_HI: state_nxt = S_WR_LO;
      S_WR_LO: begin
        buf_raddr = IX_DATA[7:0] + {w_r, 1'b0} + 8'h01;
        hi_nxt = buf_q;
        state_nxt = S_WR_DO;
      end
      S_WR_DO: begin
        mwe = 1'b1;
        mwaddr = a_r[REG_AW-1:0] + {3'h0, w_r};
        mwdata = {hi_r, buf_q}; // High byte first on the wire
        w_nxt = w_r + 7'h01;
        state_nxt = ({9'h000, w_r} + 16'h0001 == q_r) ? S_TX_PREP : S_WR_HI;
      end
      S_TX_PREP: state_nxt = S_TX_LOAD; // Register read in flight
      S_TX_LOAD: begin
        tx_byte_nxt = tx_sel;
        tx_go_nxt = 1'b1;
        if (idx_r < tx_len_r) txcrc_nxt = crc16_byte(txcrc_r, tx_sel);
        state_nxt = S_TX_WAIT;
      end
      S_TX_WAIT: begin
        if (tx_done) begin
          idx_nxt = idx_r + 8'h01;
          state_nxt = (idx_r == tx_len_r + 8'h01) ? S_APPLY : S_TX_PREP;
        end
      end
      S_APPLY: begin
        frame_clr = 1'b1;
        state_nxt = S_RX;
      end
      default: state_nxt = S_RX;
    endcase
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Side effects of master writes; new address and framing wait for the reply
  always_comb begin
    pend_slave_nxt = pend_slave_r;
    pend_cfg_nxt = pend_cfg_r;
    slave_nxt = o_slave_addr;
    cfg_nxt = o_frame_cfg;
    meas_req_nxt = 1'b0;
    meas_mask_nxt = o_meas_mask;
    coef_nxt = o_coef_mask;
    wr_addr_nxt = mwe ? mwaddr : o_wr_addr;
    wr_data_nxt = mwe ? mwdata : o_wr_data;
    if (mwe) begin
      case ({6'h00, mwaddr})
        REG_SLAVE: begin
          if (mwdata[15:8] == 8'h00 && mwdata[7:0] >= ADDR_MIN && mwdata[7:0] <= ADDR_MAX)
            pend_slave_nxt = mwdata[7:0];
        end
        REG_FRAME: if (mwdata <= {14'h0000, CFG_ODD}) pend_cfg_nxt = mwdata[1:0];
        REG_MEAS: begin
          meas_req_nxt = 1'b1; // Bit per item, temperature first
          meas_mask_nxt = mwdata;
        end
        REG_COEF_HI: coef_nxt[31:16] = mwdata;
        REG_COEF_LO: coef_nxt[15:0] = mwdata;
        default: ;
      endcase
    end
    if (state_r == S_APPLY) begin
      slave_nxt = pend_slave_r;
      cfg_nxt = pend_cfg_r;
    end
    upd_ready_nxt = (state_nxt != S_WR1) && (state_nxt != S_WR_DO);
    tx_en_nxt = (state_nxt == S_TX_PREP) || (state_nxt == S_TX_LOAD) || (state_nxt == S_TX_WAIT);
  end

  ////////////////////////////////////////////////////////////////////////////////
  always_ff @(posedge i_clk_sys or negedge i_rst_n) begin
    if (!i_rst_n) begin
      state_r <= S_RX;
      cnt_r <= 9'h000;
      bad_r <= 1'b0;
      sil_r <= 17'h00000;
      crc_r <= CRC_INIT;
      dst_r <= 8'h00;
      fc_r <= 8'h00;
      a_r <= 16'h0000;
      q_r <= 16'h0000;
      bc_r <= 8'h00;
      exc_r <= EXC_NONE;
      tx_len_r <= 8'h00;
      idx_r <= 8'h00;
      txcrc_r <= CRC_INIT;
      w_r <= 7'h00;
      hi_r <= 8'h00;
      tx_byte_r <= 8'h00;
      tx_go_r <= 1'b0;
      o_tx_en <= 1'b0;
      o_upd_ready <= 1'b1;
      pend_slave_r <= DEF_ADDR;
      pend_cfg_r <= CFG_TWO_STOP;
      o_slave_addr <= DEF_ADDR;
      o_frame_cfg <= CFG_TWO_STOP;
      o_wr_strobe <= 1'b0;
      o_wr_addr <= '0;
      o_wr_data <= 16'h0000;
      o_meas_req <= 1'b0;
      o_meas_mask <= 16'h0000;
      o_coef_mask <= 32'h00000000;
    end else begin
      state_r <= state_nxt;
      cnt_r <= cnt_nxt;
      bad_r <= bad_nxt;
      sil_r <= sil_nxt;
      crc_r <= crc_nxt;
      dst_r <= dst_nxt;
      fc_r <= fc_nxt;
      a_r <= a_nxt;
      q_r <= q_nxt;
      bc_r <= bc_nxt;
      exc_r <= exc_nxt;
      tx_len_r <= tx_len_nxt;
      idx_r <= idx_nxt;
      txcrc_r <= txcrc_nxt;
      w_r <= w_nxt;
      hi_r <= hi_nxt;
      tx_byte_r <= tx_byte_nxt;
      tx_go_r <= tx_go_nxt;
      o_tx_en <= tx_en_nxt;
      o_upd_ready <= upd_ready_nxt;
      pend_slave_r <= pend_slave_nxt;
      pend_cfg_r <= pend_cfg_nxt;
      o_slave_addr <= slave_nxt;
      o_frame_cfg <= cfg_nxt;
      o_wr_strobe <= mwe;
      o_wr_addr <= wr_addr_nxt;
      o_wr_data <= wr_data_nxt;
      o_meas_req <= meas_req_nxt;
      o_meas_mask <= meas_mask_nxt;
      o_coef_mask <= coef_nxt;
    end
  end
endmodule : mba_slave

// file: mba_slave_asserts.sv
// Port-level assertions for the slave access block
`timescale 1ns/10ps
module mba_slave_asserts
  import mba_pkg::*;
(
  input wire logic i_clk_sys,
  input wire logic i_rst_n,
  input wire logic o_tx,
  input wire logic o_tx_en,
  input wire logic [7:0] o_slave_addr,
  input wire logic [1:0] o_frame_cfg,
  input wire logic o_wr_strobe,
  input wire logic [REG_AW-1:0] o_wr_addr,
  input wire logic o_meas_req
);
  default clocking @(posedge i_clk_sys); endclocking
  default disable iff (!i_rst_n);
  // Reply starts from an idle line before its start bit
  sequence s_lead;
    o_tx [*2];
  endsequence
  a_tx_idle_high: assert property (!o_tx_en |-> o_tx) else $error("tx low while idle");
  a_reply_lead: assert property ($rose(o_tx_en) |-> s_lead) else $error("no idle lead");
  a_addr_legal: assert property (o_slave_addr inside {[8'h01:8'hf7]}) else $error("addr");
  a_cfg_legal: assert property (o_frame_cfg <= 2'h2) else $error("cfg out of range");
  a_cfg_steady: assert property (o_tx_en |-> $stable(o_frame_cfg)) else $error("cfg moved");
  a_meas_write: assert property (o_meas_req |-> o_wr_strobe && o_wr_addr == 10'h001) else
    $error("meas pulse without write");
  a_meas_single: assert property (o_meas_req |=> !o_meas_req) else $error("meas pulse long");
  a_write_quiet: assert property (o_wr_strobe |-> !$past(o_tx_en)) else
    $error("write during reply");
endmodule : mba_slave_asserts

bind mba_slave mba_slave_asserts i_chk (.i_clk_sys(i_clk_sys), .i_rst_n(i_rst_n), .o_tx(o_tx),
  .o_tx_en(o_tx_en), .o_slave_addr(o_slave_addr), .o_frame_cfg(o_frame_cfg),
  .o_wr_strobe(o_wr_strobe), .o_wr_addr(o_wr_addr), .o_meas_req(o_meas_req));

// file: mba_master.sv
// Behavioural bus master standing on the far side of the serial link
`timescale 1ns/10ps
module mba_master
  import mba_pkg::*;
#(
  parameter int BIT_CYC_P = BIT_CYC
) (
  input wire logic i_clk_sys,
  input wire logic i_tx,
  input wire logic i_tx_en,
  output logic o_rx
);
  logic [7:0] rx_q[$];
  logic [7:0] b;
  initial o_rx = 1'b1;
  ////////////////////////////////////////////////////////////////////////////
  // Check sequence, kept apart from the design's helper
  function automatic logic [15:0] crc(input logic [7:0] m[$]);
    logic [15:0] c;
    c = 16'hffff;
    foreach (m[i]) begin
      c ^= {8'h00, m[i]};
      for (int k = 0; k < 8; k++) c = c[0] ? ((c >> 1) ^ 16'ha001) : (c >> 1);
    end
    return c;
  endfunction : crc
  // One character: start, data LSB first, two stops; line left high after
  task automatic put(input logic [7:0] d);
    logic [10:0] f;
    f = {2'b11, d, 1'b0};
    for (int i = 0; i < 11; i++) begin
      o_rx = f[i];
      repeat (BIT_CYC_P) @(negedge i_clk_sys);
    end
  endtask : put
  // Reply characters sampled mid-bit; a missing stop bit drops the byte
  always begin
    @(negedge i_tx);
    if (i_tx_en) begin
      repeat (BIT_CYC_P / 2) @(posedge i_clk_sys);
      for (int i = 0; i < 8; i++) begin
        repeat (BIT_CYC_P) @(posedge i_clk_sys);
        b[i] = i_tx;
      end
      repeat (BIT_CYC_P) @(posedge i_clk_sys);
      if (i_tx === 1'b1) rx_q.push_back(b);
    end
  end
endmodule : mba_master

// file: mba_slave_tb.sv
// Self-checking bench for the slave access block
`timescale 1ns/10ps
module mba_slave_tb;
  import mba_pkg::*;
  logic i_clk_sys = 1'b0;
  logic i_rst_n = 1'b0;
  logic rx, o_tx, o_tx_en, o_upd_ready, o_wr_strobe, o_meas_req, meas_seen = 1'b0;
  logic [7:0] o_slave_addr;
  logic [1:0] o_frame_cfg;
  logic [REG_AW-1:0] o_wr_addr;
  logic [15:0] o_wr_data, o_meas_mask;
  logic [31:0] o_coef_mask;
  int checks = 0;
  int fail_count = 0;
  int cyc = 0;
  localparam int TB_BIT = 16;
  logic [26:0] upd = '0;
  always #20 i_clk_sys = ~i_clk_sys;
  // Short bit period and silence so frames close quickly
  mba_slave #(.T35_CYC(200), .BIT_CYC_P(TB_BIT)) i_mba_slave (.i_clk_sys(i_clk_sys),
    .i_rst_n(i_rst_n), .i_rx(rx), .i_upd_valid(upd[26]), .i_upd_addr(upd[25:16]),
    .i_upd_data(upd[15:0]), .o_upd_ready(o_upd_ready),
    .o_tx(o_tx), .o_tx_en(o_tx_en), .o_slave_addr(o_slave_addr), .o_frame_cfg(o_frame_cfg),
    .o_wr_strobe(o_wr_strobe), .o_wr_addr(o_wr_addr), .o_wr_data(o_wr_data),
    .o_meas_req(o_meas_req), .o_meas_mask(o_meas_mask), .o_coef_mask(o_coef_mask));
  mba_master #(.BIT_CYC_P(TB_BIT)) i_mba_master (.i_clk_sys(i_clk_sys), .i_tx(o_tx),
    .i_tx_en(o_tx_en), .o_rx(rx));
  always @(posedge i_clk_sys) if (o_meas_req) meas_seen <= 1'b1;
  ////////////////////////////////////////////////////////////////////////////
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks++;
    if (got !== exp) begin
      fail_count++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk
  // Send a framed request and compare the whole reply, check bytes included
  task automatic xfer(input string nm, input logic [7:0] req[$], input logic [7:0] exp[$]);
    logic [15:0] c;
    int n;
    int want;
    n = 0;
    want = exp.size() ? exp.size() + 2 : 0;
    i_mba_master.rx_q.delete();
    c = i_mba_master.crc(req);
    req.push_back(c[7:0]);
    req.push_back(c[15:8]);
    foreach (req[i]) i_mba_master.put(req[i]);
    while ((i_mba_master.rx_q.size() < want || n < 3000) && n < 400000) begin
      @(negedge i_clk_sys);
      n++;
    end
    repeat (2 * TB_BIT) @(negedge i_clk_sys);
    if (want) begin
      c = i_mba_master.crc(exp);
      exp.push_back(c[7:0]);
      exp.push_back(c[15:8]);
    end
    chk(i_mba_master.rx_q.size(), exp.size());
    foreach (exp[i]) if (i < i_mba_master.rx_q.size()) chk(i_mba_master.rx_q[i], exp[i]);
    $display("test %s finished", nm);
  endtask : xfer
  ////////////////////////////////////////////////////////////////////////////
  task automatic t_meas();
    xfer("meas", '{8'h0a, 8'h06, 8'h00, 8'h01, 8'h00, 8'h1f},
      '{8'h0a, 8'h06, 8'h00, 8'h01, 8'h00, 8'h1f});
    chk(meas_seen, 1);
    chk(o_meas_mask, 32'h001f);
    chk({o_wr_addr, o_wr_data}, 32'h0001001f);
  endtask : t_meas
  task automatic t_float();
    chk(o_upd_ready, 1);
    upd = {1'b1, 10'h053, 16'h3f80};
    @(negedge i_clk_sys);
    upd = {1'b1, 10'h054, 16'h0000};
    @(negedge i_clk_sys);
    upd = '0;
    xfer("float", '{8'h0a, 8'h03, 8'h00, 8'h53, 8'h00, 8'h02},
      '{8'h0a, 8'h03, 8'h04, 8'h3f, 8'h80, 8'h00, 8'h00});
  endtask : t_float
  task automatic t_read();
    xfer("read", '{8'h0a, 8'h03, 8'h00, 8'h01, 8'h00, 8'h01},
      '{8'h0a, 8'h03, 8'h02, 8'h00, 8'h1f});
  endtask : t_read
  task automatic t_multi();
    xfer("multi", '{8'h0a, 8'h10, 8'h01, 8'h4c, 8'h00, 8'h02, 8'h04, 8'h12, 8'h34, 8'h56, 8'h78},
      '{8'h0a, 8'h10, 8'h01, 8'h4c, 8'h00, 8'h02});
    chk(o_coef_mask, 32'h12345678);
  endtask : t_multi
  task automatic t_ident();
    xfer("ident", '{8'h0a, 8'h11}, '{8'h0a, 8'h11, 8'h02, 8'h5a, 8'hff});
  endtask : t_ident
  task automatic t_badfn();
    xfer("badfn", '{8'h0a, 8'h2b, 8'h00, 8'h00, 8'h00, 8'h01}, '{8'h0a, 8'hab, 8'h01});
  endtask : t_badfn
  task automatic t_other();
    xfer("other", '{8'h0b, 8'h03, 8'h00, 8'h01, 8'h00, 8'h01}, '{});
    chk(o_slave_addr, 32'h000a);
    chk(o_frame_cfg, 32'h0000);
  endtask : t_other
  ////////////////////////////////////////////////////////////////////////////
  task automatic results();
    $display("checks=%0d fail_count=%0d", checks, fail_count);
    if (fail_count == 0 && checks > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask : results
  // Seven short frames at sixteen clocks a bit fit well inside this
  always @(posedge i_clk_sys) begin
    cyc <= cyc + 1;
    if (cyc == 60000) begin
      fail_count++;
      results();
    end
  end
  initial begin
    repeat (20) @(negedge i_clk_sys);
    i_rst_n = 1'b1;
    repeat (5) @(negedge i_clk_sys);
    t_other();
    t_meas();
    t_read();
    t_float();
    t_multi();
    t_ident();
    t_badfn();
    results();
  end
endmodule : mba_slave_tb
